// ---- memlink_pkg.sv ----
package memlink_pkg;

    // ------------------------------------------------------------
    // Widths
    // ------------------------------------------------------------
    localparam int ADDR_W = 15;
    localparam int BANK_W = 3;
    localparam int DATA_W = 8;
    localparam int COL_W = 10;
    localparam int AP_BIT = 10;

    // ------------------------------------------------------------
    // Mode register and extended mode register one fields
    // ------------------------------------------------------------
    localparam int EMR1_NDIFF_BIT = 10;
    localparam int EMR1_RSTB_BIT = 11;
    localparam int EMR1_AL_LSB = 3;
    localparam int MR_CL_LSB = 4;
    localparam int MR_BL_LSB = 0;
    localparam logic [2:0] BL_CODE_8 = 3'h3;

    // ------------------------------------------------------------
    // Reset values
    // ------------------------------------------------------------
    localparam logic [2:0] CL_RST = 3'h3;
    localparam logic [2:0] AL_RST = 3'h0;

    // ------------------------------------------------------------
    // Command codes {cs_n, ras_n, cas_n, we_n}
    // ------------------------------------------------------------
    localparam logic [3:0] CMD_MRS = 4'h0;
    localparam logic [3:0] CMD_REF = 4'h1;
    localparam logic [3:0] CMD_PRE = 4'h2;
    localparam logic [3:0] CMD_ACT = 4'h3;
    localparam logic [3:0] CMD_WR = 4'h4;
    localparam logic [3:0] CMD_RD = 4'h5;
    localparam logic [3:0] CMD_NOP = 4'h7;
    localparam logic [3:0] CMD_DESEL = 4'hF;

    // Link clock divider: half period in system clocks
    localparam int LCLK_HALF = 4;

    typedef enum logic [2:0] {
        OP_NONE, OP_ACT, OP_RD, OP_WR, OP_PRE, OP_REF, OP_MRS
    } mem_op_t;

endpackage

// ---- memlink_if.sv ----
`timescale 1ns/1ps
interface memlink_if;
    import memlink_pkg::*;
    logic lclk;
    logic cke;
    logic cs_n;
    logic ras_n;
    logic cas_n;
    logic we_n;
    logic odt;
    logic [BANK_W-1:0] ba;
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] dq_c;
    logic dq_c_oe;
    logic [DATA_W-1:0] dq_d;
    logic dq_d_oe;
    logic dqs_c;
    logic dqs_c_oe;
    logic dqs_d;
    logic dqs_d_oe;
    logic dqs_n_d;
    logic dqs_n_d_oe;
    logic dm_c;
    logic dm_c_oe;
    logic rstb_d;
    logic rstb_d_oe;
    logic rstb_n_d;
    logic rstb_n_d_oe;
    // Resolved wire levels
    wire [DATA_W-1:0] dq = dq_d_oe ? dq_d : dq_c;
    wire dqs = dqs_d_oe ? dqs_d : dqs_c;
    wire dm = rstb_d_oe ? rstb_d : dm_c;

    modport ctrl (
        output lclk, cke, cs_n, ras_n, cas_n, we_n, odt, ba, addr,
        output dq_c, dq_c_oe, dqs_c, dqs_c_oe, dm_c, dm_c_oe,
        input dq, dqs
    );
    modport mem (
        input lclk, cke, cs_n, ras_n, cas_n, we_n, odt, ba, addr,
        input dq, dqs, dm,
        output dq_d, dq_d_oe, dqs_d, dqs_d_oe, dqs_n_d, dqs_n_d_oe,
        output rstb_d, rstb_d_oe, rstb_n_d, rstb_n_d_oe
    );
endinterface

// ---- pin_sync.sv ----
`timescale 1ns/1ps
module pin_sync #(
    parameter int W = 1
) (
    input wire logic clk,
    input wire logic nrst,
    input wire logic [W-1:0] din,
    output logic [W-1:0] dout
);
    logic [W-1:0] s1_reg;
    logic [W-1:0] s2_reg;
    logic [W-1:0] s3_reg;

    always_ff @(posedge clk) begin
        if (!nrst) begin
            s1_reg <= '0;
            s2_reg <= '0;
            s3_reg <= '0;
        end else begin
            s1_reg <= din;
            s2_reg <= s1_reg;
            s3_reg <= s2_reg;
        end
    end

    // Each bit changes only once stages two and three agree
    always_ff @(posedge clk) begin
        if (!nrst) begin
            dout <= '0;
        end else begin
            for (int i = 0; i < W; i++) begin
                if (s2_reg[i] == s3_reg[i]) begin
                    dout[i] <= s3_reg[i];
                end
            end
        end
    end
endmodule

// ---- mem_end.sv ----
`timescale 1ns/1ps
// Notes on behaviour
// - Activate latches full row address.
// - Column from low ten bits, bit ten autoprecharge.
// - Bank lines select target bank.
// - Termination follows registered termination input.
// - Strobe driven by whichever side sends data.
// - Read strobe edge aligned, write centre aligned.
// - Complement strobe only in differential mode.
// - Non-differential mode: complement pins left alone.
// - Chip select high masks all commands.
// - Four control lines form the command.
// - Masked write beats are not stored.
// - Mask sampled on both strobe edges.
// - Read strobe option turns mask pin output.
// - Read strobe option disables write masking.
// - Complement read strobe needs read strobe option and differential mode.
// - Control inputs sampled on rising link clock.
// - Read data on both link clock edges.
// - Clock enable gates internal clocking.
// - Read latency is additive plus CAS.
// - Bursts are four or eight beats.
module mem_end
    import memlink_pkg::*;
#(
    parameter int NBANK = 8,
    parameter int ROWS = 16,
    parameter int COLS = 16
) (
    // System
    input wire logic clk,
    input wire logic nrst,
    // Link
    memlink_if.mem link,
    // Status
    output logic term_on,
    output logic clocking_on,
    output logic [ADDR_W-1:0] open_row [NBANK],
    output logic [NBANK-1:0] bank_open
);
    // ------------------------------------------------------------
    // Input sampling
    // ------------------------------------------------------------
    localparam int SW = 4 + 1 + 1 + BANK_W + ADDR_W + DATA_W + 3;
    logic [SW-1:0] sync_out;
    logic lclk_s, lclk_d_reg, rise, fall;
    logic [3:0] cmd_pins;
    logic cke_s, odt_s, dqs_s, dm_s, dqs_d_reg;
    logic [BANK_W-1:0] ba_s;
    logic [ADDR_W-1:0] addr_s;
    logic [DATA_W-1:0] dq_s;

    pin_sync #(.W(SW)) pin_sync_inst (
        .clk(clk),
        .nrst(nrst),
        .din({link.lclk, link.cke, link.odt, link.cs_n, link.ras_n, link.cas_n,
              link.we_n, link.ba, link.addr, link.dq, link.dqs, link.dm}),
        .dout(sync_out)
    );
    assign {lclk_s, cke_s, odt_s, cmd_pins, ba_s, addr_s, dq_s, dqs_s, dm_s} = sync_out;

    always_ff @(posedge clk) begin
        if (!nrst) begin
            lclk_d_reg <= 1'b0;
            dqs_d_reg <= 1'b0;
        end else begin
            lclk_d_reg <= lclk_s;
            dqs_d_reg <= dqs_s;
        end
    end
    assign rise = lclk_s & ~lclk_d_reg;
    assign fall = ~lclk_s & lclk_d_reg;

    // ------------------------------------------------------------
    // Command decode
    // ------------------------------------------------------------
    logic cke_reg;
    mem_op_t op;
    always_comb begin
        op = OP_NONE;
        if (rise && cke_reg && !cmd_pins[3]) begin
            unique case (cmd_pins)
                CMD_MRS: op = OP_MRS;
                CMD_REF: op = OP_REF;
                CMD_PRE: op = OP_PRE;
                CMD_ACT: op = OP_ACT;
                CMD_WR: op = OP_WR;
                CMD_RD: op = OP_RD;
                default: op = OP_NONE;
            endcase
        end
    end

    always_ff @(posedge clk) begin
        if (!nrst) begin
            cke_reg <= 1'b0;
            term_on <= 1'b0;
        end else if (rise) begin
            cke_reg <= cke_s;
            term_on <= odt_s;
        end
    end
    assign clocking_on = cke_reg;

    // ------------------------------------------------------------
    // Mode registers
    // ------------------------------------------------------------
    logic [2:0] cl_reg, al_reg;
    logic bl8_reg, ndiff_reg, rstb_en_reg;
    always_ff @(posedge clk) begin
        if (!nrst) begin
            cl_reg <= CL_RST;
            al_reg <= AL_RST;
            bl8_reg <= 1'b0;
            ndiff_reg <= 1'b0;
            rstb_en_reg <= 1'b0;
        end else if (op == OP_MRS) begin
            if (ba_s == 3'h0) begin
                cl_reg <= addr_s[MR_CL_LSB +: 3];
                bl8_reg <= (addr_s[MR_BL_LSB +: 3] == BL_CODE_8);
            end else if (ba_s == 3'h1) begin
                al_reg <= addr_s[EMR1_AL_LSB +: 3];
                ndiff_reg <= addr_s[EMR1_NDIFF_BIT];
                rstb_en_reg <= addr_s[EMR1_RSTB_BIT];
            end
        end
    end

    // ------------------------------------------------------------
    // Banks and storage
    // ------------------------------------------------------------
    logic [DATA_W-1:0] mem_arr [NBANK*ROWS*COLS];
    logic pend_rd, pend_wr, act_rd, act_wr, ap_reg, burst_done;
    logic [BANK_W-1:0] bk_reg;
    always_ff @(posedge clk) begin
        if (!nrst) begin
            bank_open <= '0;
            for (int b = 0; b < NBANK; b++) begin
                open_row[b] <= '0;
            end
        end else begin
            unique case (op)
                OP_ACT: begin
                    bank_open[ba_s] <= 1'b1;
                    open_row[ba_s] <= addr_s;
                end
                OP_PRE: begin
                    if (addr_s[AP_BIT]) begin
                        bank_open <= '0;
                    end else begin
                        bank_open[ba_s] <= 1'b0;
                    end
                end
                default: begin
                end
            endcase
            if (burst_done && ap_reg) begin
                bank_open[bk_reg] <= 1'b0;
            end
        end
    end

    // ------------------------------------------------------------
    // Burst engine
    // ------------------------------------------------------------
    logic [3:0] wait_reg;
    logic [3:0] beat_reg;
    logic [COL_W-1:0] col_reg;
    logic [3:0] nbeats;
    assign nbeats = bl8_reg ? 4'h8 : 4'h4;
    assign burst_done = (act_rd || act_wr) && beat_reg == nbeats;

    function automatic int idx(input logic [BANK_W-1:0] b, input logic [ADDR_W-1:0] r,
                               input logic [COL_W-1:0] c);
        idx = (int'(b) * ROWS + (int'(r) % ROWS)) * COLS + (int'(c) % COLS);
    endfunction

    always_ff @(posedge clk) begin
        if (!nrst) begin
            wait_reg <= '0;
            beat_reg <= '0;
            pend_rd <= 1'b0;
            pend_wr <= 1'b0;
            act_rd <= 1'b0;
            act_wr <= 1'b0;
            ap_reg <= 1'b0;
            bk_reg <= '0;
            col_reg <= '0;
        end else if (op == OP_RD || op == OP_WR) begin
            pend_rd <= (op == OP_RD);
            pend_wr <= (op == OP_WR);
            act_rd <= 1'b0;
            act_wr <= 1'b0;
            bk_reg <= ba_s;
            col_reg <= addr_s[COL_W-1:0];
            ap_reg <= addr_s[AP_BIT];
            beat_reg <= '0;
            // Writes arm one rise before write latency: the first strobe edge
            // arrives with that sampled rise and would otherwise be missed
            wait_reg <= (op == OP_RD) ? {1'b0, al_reg} + {1'b0, cl_reg}
                                      : {1'b0, al_reg} + {1'b0, cl_reg} - 4'h2;
        end else begin
            if ((pend_rd || pend_wr) && rise) begin
                if (wait_reg <= 4'h1) begin
                    act_rd <= pend_rd;
                    act_wr <= pend_wr;
                    pend_rd <= 1'b0;
                    pend_wr <= 1'b0;
                end else begin
                    wait_reg <= wait_reg - 4'h1;
                end
            end
            if (act_rd && (rise || fall)) begin
                beat_reg <= beat_reg + 4'h1;
            end
            if (act_wr && dqs_s != dqs_d_reg) begin
                beat_reg <= beat_reg + 4'h1;
            end
            // Reads keep the lane until the last beat's half period ends
            if (burst_done && (act_wr || rise || fall)) begin
                act_rd <= 1'b0;
                act_wr <= 1'b0;
            end
        end
    end

    // Write capture on both strobe edges
    always_ff @(posedge clk) begin
        if (act_wr && dqs_s != dqs_d_reg && beat_reg < nbeats) begin
            if (rstb_en_reg || !dm_s) begin
                mem_arr[idx(bk_reg, open_row[bk_reg], col_reg + COL_W'(beat_reg))] <= dq_s;
            end
        end
    end

    // ------------------------------------------------------------
    // Read drive
    // ------------------------------------------------------------
    logic rd_drv;
    assign rd_drv = act_rd && beat_reg < nbeats;
    always_ff @(posedge clk) begin
        if (!nrst) begin
            link.dq_d <= '0;
            link.dq_d_oe <= 1'b0;
            link.dqs_d <= 1'b0;
        end else begin
            link.dq_d_oe <= act_rd;
            if (rd_drv && (rise || fall)) begin
                link.dq_d <= mem_arr[idx(bk_reg, open_row[bk_reg],
                                         col_reg + COL_W'(beat_reg))];
                link.dqs_d <= ~beat_reg[0];
            end else if (!rd_drv) begin
                link.dqs_d <= 1'b0;
            end
        end
    end
    assign link.dqs_d_oe = link.dq_d_oe;
    assign link.dqs_n_d = ~link.dqs_d;
    assign link.dqs_n_d_oe = link.dq_d_oe && !ndiff_reg;
    assign link.rstb_d = link.dqs_d;
    assign link.rstb_d_oe = link.dq_d_oe && rstb_en_reg;
    assign link.rstb_n_d = ~link.dqs_d;
    assign link.rstb_n_d_oe = link.dq_d_oe && rstb_en_reg && !ndiff_reg;
endmodule

// ---- ctrl_end.sv ----
`timescale 1ns/1ps
module ctrl_end
    import memlink_pkg::*;
(
    // System
    input wire logic clk,
    input wire logic nrst,
    // Link
    memlink_if.ctrl link,
    // User command
    input wire logic req,
    input wire logic [3:0] req_cmd,
    input wire logic [BANK_W-1:0] req_ba,
    input wire logic [ADDR_W-1:0] req_addr,
    input wire logic [DATA_W-1:0] wr_data [8],
    input wire logic [7:0] wr_mask,
    input wire logic [3:0] wr_lat,
    input wire logic [3:0] rd_lat,
    input wire logic bl8,
    input wire logic cke_in,
    input wire logic odt_in,
    output logic busy,
    output logic [DATA_W-1:0] rd_data [8],
    output logic rd_valid
);
    logic [7:0] div_reg;
    logic lclk_reg;
    logic [DATA_W:0] rsync;
    logic dqs_s, dqs_d_reg;
    logic [DATA_W-1:0] dq_s;
    logic [3:0] cnt_reg, beat_reg;
    logic is_wr, is_rd, bursting, burst_end;
    logic [3:0] nbeats;
    assign nbeats = bl8 ? 4'h8 : 4'h4;

    // Link clock from divider; edges are known locally
    always_ff @(posedge clk) begin
        if (!nrst) begin
            div_reg <= '0;
            lclk_reg <= 1'b0;
        end else if (div_reg == 8'(LCLK_HALF - 1)) begin
            div_reg <= '0;
            lclk_reg <= ~lclk_reg;
        end else begin
            div_reg <= div_reg + 8'h1;
        end
    end
    logic fall_next, rise_next;
    assign rise_next = div_reg == 8'(LCLK_HALF - 1) && !lclk_reg;
    assign fall_next = div_reg == 8'(LCLK_HALF - 1) && lclk_reg;
    assign link.lclk = lclk_reg;

    pin_sync #(.W(DATA_W + 1)) pin_sync_inst (
        .clk(clk),
        .nrst(nrst),
        .din({link.dq, link.dqs}),
        .dout(rsync)
    );
    assign {dq_s, dqs_s} = rsync;

    // Commands change on the falling link edge, centred on the rising one
    always_ff @(posedge clk) begin
        if (!nrst) begin
            {link.cs_n, link.ras_n, link.cas_n, link.we_n} <= CMD_DESEL;
            link.ba <= '0;
            link.addr <= '0;
            link.cke <= 1'b0;
            link.odt <= 1'b0;
            cnt_reg <= '0;
            is_wr <= 1'b0;
            is_rd <= 1'b0;
        end else if (fall_next) begin
            link.cke <= cke_in;
            link.odt <= odt_in;
            {link.cs_n, link.ras_n, link.cas_n, link.we_n} <= CMD_NOP;
            if (req && !busy) begin
                {link.cs_n, link.ras_n, link.cas_n, link.we_n} <= req_cmd;
                link.ba <= req_ba;
                link.addr <= req_addr;
                is_wr <= req_cmd == CMD_WR;
                is_rd <= req_cmd == CMD_RD;
                cnt_reg <= (req_cmd == CMD_WR) ? wr_lat : rd_lat + 4'h1;
            end else if (cnt_reg != 4'h0 && !bursting) begin
                cnt_reg <= cnt_reg - 4'h1;
            end
        end else if (burst_end) begin
            is_wr <= 1'b0;
            is_rd <= 1'b0;
        end
    end
    assign bursting = (is_wr || is_rd) && cnt_reg == 4'h0;
    assign burst_end = bursting && beat_reg == nbeats;
    assign busy = is_wr || is_rd;

    // Write data change on link edges, strobe at mid beat
    logic mid;
    assign mid = div_reg == 8'(LCLK_HALF / 2 - 1);
    always_ff @(posedge clk) begin
        if (!nrst) begin
            beat_reg <= '0;
            link.dq_c <= '0;
            link.dq_c_oe <= 1'b0;
            link.dqs_c <= 1'b0;
            link.dqs_c_oe <= 1'b0;
            link.dm_c <= 1'b0;
            link.dm_c_oe <= 1'b0;
        end else if (!bursting) begin
            beat_reg <= '0;
            // First beat waits on the lane before the first strobe edge
            link.dq_c <= wr_data[0];
            link.dm_c <= wr_mask[0];
            link.dq_c_oe <= 1'b0;
            link.dqs_c_oe <= 1'b0;
            link.dm_c_oe <= 1'b0;
            link.dqs_c <= 1'b0;
        end else if (is_wr) begin
            link.dq_c_oe <= 1'b1;
            link.dqs_c_oe <= 1'b1;
            link.dm_c_oe <= 1'b1;
            if ((rise_next || fall_next) && beat_reg < nbeats) begin
                link.dq_c <= wr_data[beat_reg[2:0]];
                link.dm_c <= wr_mask[beat_reg[2:0]];
            end
            if (mid && beat_reg < nbeats) begin
                link.dqs_c <= ~beat_reg[0];
                beat_reg <= beat_reg + 4'h1;
            end
        end else if (dqs_s != dqs_d_reg) begin
            beat_reg <= beat_reg + 4'h1;
        end
    end

    always_ff @(posedge clk) begin
        if (!nrst) begin
            dqs_d_reg <= 1'b0;
            rd_valid <= 1'b0;
            for (int i = 0; i < 8; i++) begin
                rd_data[i] <= '0;
            end
        end else begin
            dqs_d_reg <= dqs_s;
            rd_valid <= is_rd && burst_end;
            if (is_rd && bursting && dqs_s != dqs_d_reg && beat_reg < nbeats) begin
                rd_data[beat_reg[2:0]] <= dq_s;
            end
        end
    end
endmodule

// ---- ddr2_link_asserts.sv ----
`timescale 1ns/1ps
module ddr2_link_asserts
    import memlink_pkg::*;
(
    // System
    input wire logic clk,
    input wire logic nrst,
    // Command pins
    input wire logic lclk,
    input wire logic cke,
    input wire logic cs_n,
    input wire logic ras_n,
    input wire logic cas_n,
    input wire logic we_n,
    input wire logic [BANK_W-1:0] ba,
    input wire logic [ADDR_W-1:0] addr,
    // Pin enables
    input wire logic dq_c_oe,
    input wire logic dq_d_oe,
    input wire logic dqs_c_oe,
    input wire logic dqs_d_oe,
    input wire logic dqs_n_d_oe,
    input wire logic dm_c_oe,
    input wire logic rstb_d_oe,
    input wire logic rstb_n_d_oe
);
    // ----------------------------------------
    // Helper state
    // ----------------------------------------
    logic lclk_reg;
    logic ndiff_reg;
    logic rdqs_reg;
    logic [5:0] run_reg;
    wire [3:0] cmd = {cs_n, ras_n, cas_n, we_n};
    wire lrise = lclk & ~lclk_reg;

    always_ff @(posedge clk) begin
        if (!nrst) lclk_reg <= 1'b0;
        else lclk_reg <= lclk;
    end

    // Mode bits are tracked from the pins so the checker needs no device internals
    always_ff @(posedge clk) begin
        if (!nrst) begin
            ndiff_reg <= 1'b0;
            rdqs_reg <= 1'b0;
        end else if (lrise && cke && cmd == CMD_MRS && ba == 3'h1) begin
            ndiff_reg <= addr[EMR1_NDIFF_BIT];
            rdqs_reg <= addr[EMR1_RSTB_BIT];
        end
    end

    always_ff @(posedge clk) begin
        if (!nrst) run_reg <= 6'h00;
        else if (!dq_d_oe) run_reg <= 6'h00;
        else if (run_reg != 6'h3f) run_reg <= run_reg + 6'h01;
    end

    // ----------------------------------------
    // Properties
    // ----------------------------------------
    default clocking cb @(posedge clk); endclocking
    default disable iff (!nrst);

    one_driver_a: assert property (!(dq_c_oe && dq_d_oe))
        else $error("both ends drive the data lane");
    rd_strobe_a: assert property (dq_d_oe |-> dqs_d_oe)
        else $error("read data without strobe");
    wr_strobe_a: assert property (dq_c_oe |-> dqs_c_oe)
        else $error("write data without strobe");
    mask_with_data_a: assert property (dm_c_oe |-> dq_c_oe)
        else $error("mask driven outside write data");
    diff_strobe_a: assert property (dqs_n_d_oe |-> !ndiff_reg)
        else $error("complement strobe driven in single mode");
    rstb_pin_a: assert property (rstb_d_oe |-> rdqs_reg)
        else $error("read strobe pin driven while option off");
    rstb_comp_a: assert property (rstb_n_d_oe |-> rdqs_reg && !ndiff_reg)
        else $error("complement read strobe driven wrongly");
    cmd_stable_a: assert property (lrise |-> $stable({cmd, ba, addr, cke}))
        else $error("command pins move at link rise");
    rd_latency_a: assert property (lrise && cke && cmd == CMD_RD
        |-> !dq_d_oe [*8] ##[8:32] dq_d_oe)
        else $error("read data outside latency window");
    burst_len_a: assert property (run_reg <= 6'd40)
        else $error("read burst too long");

    cover property (lrise && cmd == CMD_RD);
    cover property (rstb_d_oe && dq_d_oe);
    cover property (dm_c_oe && dq_c_oe);
endmodule

// ---- ddr2_sdram_pin_interface_bench.sv ----
`timescale 1ns/1ps
module ddr2_sdram_pin_interface_bench;
    import memlink_pkg::*;
    // ----------------------------------------
    // Signals and instances
    // ----------------------------------------
    logic clk, nrst, req, bl8, cke_in, odt_in, busy, rd_valid, term_on, clocking_on;
    logic [3:0] req_cmd, wr_lat, rd_lat;
    logic [BANK_W-1:0] req_ba;
    logic [ADDR_W-1:0] req_addr;
    logic [DATA_W-1:0] wr_data [8];
    logic [DATA_W-1:0] rd_data [8];
    logic [7:0] wr_mask, bank_open;
    logic [ADDR_W-1:0] open_row [8];
    int fails, compares, rd_seen;

    memlink_if memlink_if_inst ();
    mem_end mem_end_inst (.clk(clk), .nrst(nrst), .link(memlink_if_inst),
        .term_on(term_on), .clocking_on(clocking_on), .open_row(open_row),
        .bank_open(bank_open));
    ctrl_end ctrl_end_inst (.clk(clk), .nrst(nrst), .link(memlink_if_inst),
        .req(req), .req_cmd(req_cmd), .req_ba(req_ba), .req_addr(req_addr),
        .wr_data(wr_data), .wr_mask(wr_mask), .wr_lat(wr_lat), .rd_lat(rd_lat),
        .bl8(bl8), .cke_in(cke_in), .odt_in(odt_in), .busy(busy),
        .rd_data(rd_data), .rd_valid(rd_valid));
    ddr2_link_asserts ddr2_link_asserts_inst (.clk(clk), .nrst(nrst),
        .lclk(memlink_if_inst.lclk), .cke(memlink_if_inst.cke),
        .cs_n(memlink_if_inst.cs_n), .ras_n(memlink_if_inst.ras_n),
        .cas_n(memlink_if_inst.cas_n), .we_n(memlink_if_inst.we_n),
        .ba(memlink_if_inst.ba), .addr(memlink_if_inst.addr),
        .dq_c_oe(memlink_if_inst.dq_c_oe), .dq_d_oe(memlink_if_inst.dq_d_oe),
        .dqs_c_oe(memlink_if_inst.dqs_c_oe), .dqs_d_oe(memlink_if_inst.dqs_d_oe),
        .dqs_n_d_oe(memlink_if_inst.dqs_n_d_oe), .dm_c_oe(memlink_if_inst.dm_c_oe),
        .rstb_d_oe(memlink_if_inst.rstb_d_oe),
        .rstb_n_d_oe(memlink_if_inst.rstb_n_d_oe));

    initial begin
        clk = 1'b0;
        forever #50 clk = ~clk;
    end

    always @(posedge clk) if (rd_valid === 1'b1) rd_seen++;

    // ----------------------------------------
    // Shared tasks
    // ----------------------------------------
    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        compares++;
        if (got !== exp) begin
            fails++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    // Holds the request until busy rises or 40 cycles pass, then lets the transfer drain
    task automatic issue(input logic [3:0] c, input logic [2:0] b, input logic [14:0] a);
        int n;
        n = 0;
        req <= 1'b1;
        req_cmd <= c;
        req_ba <= b;
        req_addr <= a;
        do begin
            @(posedge clk);
            n++;
        end while (busy !== 1'b1 && n < 40);
        if (c == CMD_WR || c == CMD_RD) begin
            check(32'(busy), 32'h0000_0001);
        end
        req <= 1'b0;
        n = 0;
        while (busy !== 1'b0 && n < 400) begin
            @(posedge clk);
            n++;
        end
        check(32'(busy), 32'h0000_0000);
        repeat (16) @(posedge clk);
    endtask

    task automatic mode(input logic [14:0] mr, input logic [14:0] emr);
        issue(CMD_MRS, 3'h0, mr);
        issue(CMD_MRS, 3'h1, emr);
    endtask

    task automatic wr(input logic [2:0] b, input logic [14:0] a, input logic [7:0] d,
            input logic [7:0] m);
        foreach (wr_data[i]) wr_data[i] <= d + 8'(i);
        wr_mask <= m;
        issue(CMD_WR, b, a);
    endtask

    // Beat i holds the old byte where the mask bit was set, else the new one
    task automatic rd(input logic [2:0] b, input logic [14:0] a, input logic [7:0] nw,
            input logic [7:0] old, input logic [7:0] m, input int nb);
        int seen, n;
        seen = rd_seen;
        n = 0;
        issue(CMD_RD, b, a);
        while (rd_seen == seen && n < 400) begin
            @(posedge clk);
            n++;
        end
        check(32'(rd_seen != seen), 32'h0000_0001);
        for (int i = 0; i < nb; i++) begin
            check(rd_data[i], m[i] ? old + 8'(i) : nw + 8'(i));
        end
    endtask

    task automatic stop_test();
        $display("compares=%0d fails=%0d", compares, fails);
        if (fails == 0 && compares > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask

    // ----------------------------------------
    // Scenarios
    // ----------------------------------------
    task automatic t_levels();
        check(bank_open, 8'h00);
        check(clocking_on, 1'b0);
        cke_in <= 1'b1;
        odt_in <= 1'b1;
        repeat (24) @(posedge clk);
        check(clocking_on, 1'b1);
        check(term_on, 1'b1);
        odt_in <= 1'b0;
        repeat (24) @(posedge clk);
        check(term_on, 1'b0);
    endtask

    task automatic t_commands();
        mode(15'h0033, 15'h0000);
        issue(CMD_ACT, 3'h5, 15'h6a5c);
        check(bank_open, 8'h20);
        check(open_row[5], 15'h6a5c);
        issue(4'hb, 3'h2, 15'h0011);
        check(bank_open, 8'h20);
        issue(4'h6, 3'h3, 15'h0022);
        check(bank_open, 8'h20);
        issue(CMD_NOP, 3'h4, 15'h0033);
        check(bank_open, 8'h20);
    endtask

    task automatic t_masked_write();
        wr(3'h5, 15'h0008, 8'h10, 8'h00);
        wr(3'h5, 15'h0008, 8'ha0, 8'h5a);
        rd(3'h5, 15'h0008, 8'ha0, 8'h10, 8'h5a, 8);
        rd(3'h5, 15'h0408, 8'ha0, 8'h10, 8'h5a, 8);
        check(bank_open, 8'h00);
    endtask

    task automatic t_read_strobe();
        mode(15'h0033, 15'h0c00);
        issue(CMD_ACT, 3'h5, 15'h6a5c);
        wr(3'h5, 15'h0008, 8'hc0, 8'hff);
        rd(3'h5, 15'h0008, 8'hc0, 8'h00, 8'h00, 8);
        mode(15'h0033, 15'h0800);
        rd(3'h5, 15'h0008, 8'hc0, 8'h00, 8'h00, 8);
        mode(15'h0033, 15'h0000);
        issue(CMD_PRE, 3'h5, 15'h0000);
        check(bank_open, 8'h00);
        issue(CMD_REF, 3'h0, 15'h0000);
        check(bank_open, 8'h00);
    endtask

    task automatic t_burst4();
        bl8 <= 1'b0;
        mode(15'h0032, 15'h0000);
        issue(CMD_ACT, 3'h2, 15'h0123);
        check(open_row[2], 15'h0123);
        wr(3'h2, 15'h0004, 8'h40, 8'h00);
        rd(3'h2, 15'h0004, 8'h40, 8'h00, 8'h00, 4);
    endtask

    // ----------------------------------------
    // Main sequence and watchdog
    // ----------------------------------------
    initial begin
        nrst = 1'b0;
        req = 1'b0;
        req_cmd = CMD_DESEL;
        req_ba = 3'h0;
        req_addr = 15'h0000;
        wr_mask = 8'h00;
        wr_lat = 4'h2;
        rd_lat = 4'h3;
        bl8 = 1'b1;
        cke_in = 1'b0;
        odt_in = 1'b0;
        foreach (wr_data[i]) wr_data[i] = 8'h00;
        repeat (20) @(posedge clk);
        nrst <= 1'b1;
        @(posedge clk);
        t_levels();
        t_commands();
        t_masked_write();
        t_read_strobe();
        t_burst4();
        stop_test();
    end

    // Far above the few thousand cycles the sequence needs
    initial begin
        repeat (40000) @(posedge clk);
        fails++;
        stop_test();
    end
endmodule
